// *** hdl/rtc_timer_alarm_osc_config.sv ***
// Decided for this implementation: register access over APB.
module rtc_timer_alarm_osc_config #(
  parameter logic [3:0] CAP_TARGET_RESET = rtc_cfg_pkg::CAP_RESET
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtc_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [rtc_cfg_pkg::DATA_W-1:0] pwdata,
  output logic [rtc_cfg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic alarm_event,
  output logic crystal_short,
  output logic osc_mode_select,
  output logic [rtc_cfg_pkg::CAP_W-1:0] load_cap_level
);

  logic [31:0] timer_reg;
  logic [31:0] window_reg;
  logic [31:0] alarm_reg;
  logic set_cmd_reg;
  logic cap_cmd_reg;
  logic alarm_en_reg;
  logic mode_reg;
  logic step_en_reg;
  logic [3:0] cap_target_reg;
  logic [3:0] cap_level_reg;
  logic [15:0] step_cnt_reg;
  logic short_reg;
  logic [rtc_cfg_pkg::EV_W-1:0] status_reg;
  logic [rtc_cfg_pkg::EV_W-1:0] ien_reg;
  logic irq_reg;
  logic alarm_event_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  logic [3:0] idx;
  logic aligned;
  logic mapped;
  logic setup;
  logic wr;
  logic wr_ctrl;
  logic cap_ready;
  logic alarm_match;
  logic [rtc_cfg_pkg::EV_W-1:0] events;
  logic [31:0] rd_next;

  // address decode
  assign idx = paddr[5:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel && !penable;
  assign wr = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign wr_ctrl = wr && (idx == rtc_cfg_pkg::IDX_CTRL);

  always_comb begin
    if (!aligned) begin
      mapped = 1'b0;
    end else if (idx <= rtc_cfg_pkg::IDX_CTRL) begin
      mapped = 1'b1;
    end else if (idx >= rtc_cfg_pkg::IDX_OSC && idx <= rtc_cfg_pkg::IDX_ENABLE) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // read mux
  always_comb begin
    rd_next = 32'h0000_0000;
    if (idx <= rtc_cfg_pkg::IDX_SNAP3) begin
      rd_next = {24'h00_0000, window_reg[idx[1:0]*8 +: 8]};
    end else if (idx == rtc_cfg_pkg::IDX_CTRL) begin
      rd_next = {28'h000_0000, mode_reg, alarm_en_reg, set_cmd_reg, cap_cmd_reg};
    end else if (idx == rtc_cfg_pkg::IDX_OSC) begin
      rd_next = {24'h00_0000, step_en_reg, cap_ready, 2'h0, cap_target_reg};
    end else if (idx >= rtc_cfg_pkg::IDX_ALARM_COMPARE_BYTE0 && idx <= rtc_cfg_pkg::IDX_ALARM_COMPARE_BYTE3) begin
      rd_next = {24'h00_0000, alarm_reg[idx[1:0]*8 +: 8]};
    end else if (idx == rtc_cfg_pkg::IDX_STATUS) begin
      rd_next = {29'h0000_0000, status_reg};
    end else if (idx == rtc_cfg_pkg::IDX_ENABLE) begin
      rd_next = {29'h0000_0000, ien_reg};
    end else begin
      rd_next = 32'h0000_0000;
    end
  end

  // apb answer: one wait-free access phase after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      pready_reg <= setup;
      if (setup) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
        pslverr_reg <= !mapped;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // snapshot window: capture or byte writes
  generate
    for (genvar b = 0; b < 4; b++) begin : g_bytes
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          window_reg[b*8 +: 8] <= 8'h00;
          alarm_reg[b*8 +: 8] <= 8'h00;
        end else if (ce) begin
          if (cap_cmd_reg) begin
            window_reg[b*8 +: 8] <= timer_reg[b*8 +: 8];
          end else if (wr && idx == 4'(rtc_cfg_pkg::IDX_SNAP0 + 4'(b))) begin
            window_reg[b*8 +: 8] <= pwdata[7:0];
          end
          if (wr && idx == 4'(rtc_cfg_pkg::IDX_ALARM_COMPARE_BYTE0 + 4'(b))) begin
            alarm_reg[b*8 +: 8] <= pwdata[7:0];
          end
        end
      end
    end
  endgenerate

  // running timer and preset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_reg <= 32'h0000_0000;
    end else if (ce) begin
      if (set_cmd_reg) begin
        timer_reg <= window_reg;
      end else begin
        timer_reg <= timer_reg + 32'h0000_0001;
      end
    end
  end

  // command bits: software write wins over hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_cmd_reg <= 1'b0;
      cap_cmd_reg <= 1'b0;
      alarm_en_reg <= 1'b0;
      mode_reg <= rtc_cfg_pkg::CTRL_MODE_RESET;
    end else if (ce) begin
      if (wr_ctrl && pwdata[rtc_cfg_pkg::CTRL_SET_BIT]) begin
        set_cmd_reg <= 1'b1;
      end else begin
        set_cmd_reg <= 1'b0;
      end
      if (wr_ctrl && pwdata[rtc_cfg_pkg::CTRL_CAP_BIT]) begin
        cap_cmd_reg <= 1'b1;
      end else begin
        cap_cmd_reg <= 1'b0;
      end
      if (wr_ctrl) begin
        alarm_en_reg <= pwdata[rtc_cfg_pkg::CTRL_AEN_BIT];
        mode_reg <= pwdata[rtc_cfg_pkg::CTRL_MODE_BIT];
      end
    end
  end

  // oscillator configuration and crystal pin short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_en_reg <= 1'b0;
      cap_target_reg <= CAP_TARGET_RESET;
      short_reg <= 1'b0;
    end else if (ce) begin
      if (wr && idx == rtc_cfg_pkg::IDX_OSC) begin
        step_en_reg <= pwdata[rtc_cfg_pkg::OSC_STEP_BIT];
        cap_target_reg <= pwdata[3:0];
      end
      if (wr && idx == rtc_cfg_pkg::IDX_PIN && pwdata[7:0] == rtc_cfg_pkg::PIN_SHORT_CODE) begin
        short_reg <= 1'b1;
      end else if (wr && idx == rtc_cfg_pkg::IDX_PIN && pwdata[7:0] == rtc_cfg_pkg::PIN_NORMAL_CODE) begin
        short_reg <= 1'b0;
      end
    end
  end

  // load capacitance walks one code per interval toward target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_level_reg <= CAP_TARGET_RESET;
      step_cnt_reg <= 16'h0000;
    end else if (ce) begin
      if (!step_en_reg) begin
        cap_level_reg <= cap_target_reg;
        step_cnt_reg <= 16'h0000;
      end else if (cap_level_reg == cap_target_reg) begin
        step_cnt_reg <= 16'h0000;
      end else if (step_cnt_reg == rtc_cfg_pkg::STEP_CYCLES - 16'h0001) begin
        step_cnt_reg <= 16'h0000;
        if (cap_level_reg < cap_target_reg) begin
          cap_level_reg <= cap_level_reg + 4'h1;
        end else begin
          cap_level_reg <= cap_level_reg - 4'h1;
        end
      end else begin
        step_cnt_reg <= step_cnt_reg + 16'h0001;
      end
    end
  end

  assign cap_ready = (cap_level_reg == cap_target_reg);

  // alarm compare and event sources
  assign alarm_match = alarm_en_reg && (timer_reg == alarm_reg);
  assign events = {cap_cmd_reg, set_cmd_reg, alarm_match};

  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
      ien_reg <= '0;
      irq_reg <= 1'b0;
      alarm_event_reg <= 1'b0;
    end else if (ce) begin
      if (wr && idx == rtc_cfg_pkg::IDX_CLEAR) begin
        status_reg <= (status_reg & ~pwdata[rtc_cfg_pkg::EV_W-1:0]) | events;
      end else begin
        status_reg <= status_reg | events;
      end
      if (wr && idx == rtc_cfg_pkg::IDX_ENABLE) begin
        ien_reg <= pwdata[rtc_cfg_pkg::EV_W-1:0];
      end
      irq_reg <= |(status_reg & ien_reg);
      alarm_event_reg <= alarm_match;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign alarm_event = alarm_event_reg;
  assign crystal_short = short_reg;
  assign osc_mode_select = mode_reg;
  assign load_cap_level = cap_level_reg;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_pin_short_code: assert property (
    ce && wr && idx == rtc_cfg_pkg::IDX_PIN && pwdata[7:0] == rtc_cfg_pkg::PIN_SHORT_CODE |=> crystal_short)
    else $error("short code did not short crystal pins");

  a_pin_normal_code: assert property (
    ce && wr && idx == rtc_cfg_pkg::IDX_PIN && pwdata[7:0] == rtc_cfg_pkg::PIN_NORMAL_CODE |=> !crystal_short)
    else $error("normal code did not remove short");

  a_preset_copy: assert property (
    ce && set_cmd_reg && !wr_ctrl |=> timer_reg == $past(window_reg) && !set_cmd_reg)
    else $error("preset did not load timer or clear command");

  a_capture_copy: assert property (
    ce && cap_cmd_reg && !wr_ctrl |=> window_reg == $past(timer_reg) && !cap_cmd_reg)
    else $error("capture did not load window or clear command");

  a_snap_low_byte: assert property (
    ce && cap_cmd_reg |=> window_reg[7:0] == $past(timer_reg[7:0]))
    else $error("snapshot low byte misplaced");

  a_window_hold: assert property (
    ce && !cap_cmd_reg && !(wr && idx <= rtc_cfg_pkg::IDX_SNAP3) |=> $stable(window_reg))
    else $error("window changed without capture or write");

  a_alarm_low_byte: assert property (
    ce && wr && idx == rtc_cfg_pkg::IDX_ALARM_COMPARE_BYTE0 |=> alarm_reg[7:0] == $past(pwdata[7:0]))
    else $error("alarm low byte not stored");

  a_step_off_ready: assert property (
    ce && !step_en_reg ##1 ce && !step_en_reg && !(wr && idx == rtc_cfg_pkg::IDX_OSC) |=> cap_ready)
    else $error("stepping disabled but level not at target");

  a_step_single: assert property (
    ce && step_en_reg |=> cap_level_reg == $past(cap_level_reg)
      || cap_level_reg == 4'($past(cap_level_reg) + 4'h1)
      || cap_level_reg == 4'($past(cap_level_reg) - 4'h1))
    else $error("load capacitance jumped while stepping");

  a_unused_bits_zero: assert property (
    ce && setup && !pwrite && idx == rtc_cfg_pkg::IDX_OSC |=> prdata[5:4] == 2'h0
      && prdata[6] == $past(cap_ready))
    else $error("unused bits or ready flag read wrong");

  a_alarm_flag_set: assert property (
    ce && alarm_match |=> status_reg[rtc_cfg_pkg::EV_ALARM] && alarm_event)
    else $error("alarm match did not raise flag");

  a_irq_follows: assert property (
    ce && |(status_reg & ien_reg) |=> irq)
    else $error("enabled status did not raise interrupt");

  // bus answer, clock enable freeze, set request, alarm gating and held state
  a_apb_answer: assert property (
    ce && setup |=> pready)
    else $error("setup cycle not answered in next cycle");

  a_ce_freeze: assert property (
    !ce |=> $stable(timer_reg) && $stable(window_reg) && $stable(status_reg) && $stable(cap_level_reg))
    else $error("state moved while clock enable low");

  a_set_request: assert property (
    ce && wr_ctrl && pwdata[rtc_cfg_pkg::CTRL_SET_BIT] |=> set_cmd_reg)
    else $error("set command bit not raised by write");

  a_alarm_gated: assert property (
    ce && !alarm_en_reg |=> !alarm_event)
    else $error("alarm event while alarm disabled");

  a_short_hold: assert property (
    ce && !(wr && idx == rtc_cfg_pkg::IDX_PIN) |=> $stable(crystal_short))
    else $error("crystal short changed without pin write");

  c_preset_done: cover property (set_cmd_reg ##1 !set_cmd_reg);
  c_capture_done: cover property (cap_cmd_reg ##1 !cap_cmd_reg);
  c_alarm_hit: cover property (alarm_match ##1 irq);
  c_pins_shorted: cover property (!crystal_short ##1 crystal_short);
  c_step_reached: cover property (!cap_ready ##1 cap_ready);

endmodule : rtc_timer_alarm_osc_config

// *** hdl/rtc_cfg_pkg.sv ***
package rtc_cfg_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_SNAP0 = 4'h0;
  localparam logic [3:0] IDX_SNAP3 = 4'h3;
  localparam logic [3:0] IDX_CTRL = 4'h4;
  localparam logic [3:0] IDX_OSC = 4'h6;
  localparam logic [3:0] IDX_PIN = 4'h7;
  localparam logic [3:0] IDX_ALARM_COMPARE_BYTE0 = 4'h8;
  localparam logic [3:0] IDX_ALARM_COMPARE_BYTE3 = 4'hB;
  localparam logic [3:0] IDX_STATUS = 4'hC;
  localparam logic [3:0] IDX_CLEAR = 4'hD;
  localparam logic [3:0] IDX_ENABLE = 4'hE;

  // bus widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // oscillator configuration fields
  localparam int OSC_STEP_BIT = 7;
  localparam int OSC_RDY_BIT = 6;
  localparam int CAP_W = 4;
  localparam logic [3:0] CAP_RESET = 4'h0;

  // crystal pin configuration codes
  localparam logic [7:0] PIN_SHORT_CODE = 8'hE7;
  localparam logic [7:0] PIN_NORMAL_CODE = 8'h67;

  // control register fields
  localparam int CTRL_CAP_BIT = 0;
  localparam int CTRL_SET_BIT = 1;
  localparam int CTRL_AEN_BIT = 2;
  localparam int CTRL_MODE_BIT = 3;
  localparam logic CTRL_MODE_RESET = 1'b0;

  // event bits of status, clear and enable registers
  localparam int EV_ALARM = 0;
  localparam int EV_SET = 1;
  localparam int EV_CAP = 2;
  localparam int EV_W = 3;

  // load capacitance step interval
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_TIME_NS = 1000;
  localparam logic [15:0] STEP_CYCLES = 16'(STEP_TIME_NS / CLK_PERIOD_NS);

endpackage : rtc_cfg_pkg

// *** tb/rtc_timer_alarm_osc_config_tb.sv ***
module rtc_timer_alarm_osc_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk;
  logic presetn;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [rtc_cfg_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic alarm_event;
  logic crystal_short;
  logic osc_mode_select;
  logic [3:0] load_cap_level;
  logic [31:0] rd;
  logic err;
  logic [7:0] snap0;
  int fails;
  int samples_checked;
  int n;

  rtc_timer_alarm_osc_config u_rtc_timer_alarm_osc_config (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .alarm_event(alarm_event), .crystal_short(crystal_short), .osc_mode_select(osc_mode_select),
    .load_cap_level(load_cap_level)
  );

  // free running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // counts and verdict
  task automatic conclude();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // one compare for every value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // apb transfer, holds request until pready
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd, input logic [1:0] lo = 2'b00);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, lo};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("BAD %0t no answer", $time);
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [3:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp, what);
  endtask : rdc

  // read until a bit reaches a value, bounded
  task automatic poll(input logic [3:0] idx, input int b, input logic v);
    n = 0;
    do begin
      apb(1'b0, idx, 32'h0);
      n++;
    end while (rd[b] !== v && n < 400);
    chk({31'h0, rd[b]}, {31'h0, v}, "poll bit");
    if (rd[b] !== v) conclude();
  endtask : poll

  task automatic settle();
    @(posedge pclk);
    #1;
  endtask : settle

  // main sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdc(4'(i), 32'h0, "snap reset");
      rdc(4'(i + 8), 32'h0, "alarm reset");
    end
    chk({31'h0, crystal_short}, 32'h0, "short reset");
    rdc(rtc_cfg_pkg::IDX_OSC, 32'h40, "osc reset");
    // stepping off: level follows target at once
    wr(rtc_cfg_pkg::IDX_OSC, 32'h3A);
    settle();
    settle();
    chk({28'h0, load_cap_level}, 32'hA, "level direct");
    rdc(rtc_cfg_pkg::IDX_OSC, 32'h4A, "osc readback");
    // stepping on: ready low until level walks down to target
    wr(rtc_cfg_pkg::IDX_OSC, 32'h83);
    rdc(rtc_cfg_pkg::IDX_OSC, 32'h83, "stepping busy");
    poll(rtc_cfg_pkg::IDX_OSC, 6, 1'b1);
    chk({31'h0, n >= 170}, 32'h1, "step too fast");
    chk({28'h0, load_cap_level}, 32'h3, "level stepped");
    rdc(rtc_cfg_pkg::IDX_OSC, 32'hC3, "osc ready");
    // crystal pin codes
    wr(rtc_cfg_pkg::IDX_PIN, 32'hE7);
    settle();
    chk({31'h0, crystal_short}, 32'h1, "short on");
    wr(rtc_cfg_pkg::IDX_PIN, 32'h12);
    settle();
    chk({31'h0, crystal_short}, 32'h1, "short kept");
    wr(rtc_cfg_pkg::IDX_PIN, 32'h67);
    settle();
    chk({31'h0, crystal_short}, 32'h0, "short off");
    rdc(rtc_cfg_pkg::IDX_PIN, 32'h0, "pin read");
    // preset then capture through the window
    wr(rtc_cfg_pkg::IDX_ENABLE, 32'h7);
    wr(rtc_cfg_pkg::IDX_CLEAR, 32'h7);
    for (int i = 0; i < 4; i++) wr(4'(i), 32'(8'h11 * (i + 1)));
    wr(rtc_cfg_pkg::IDX_CTRL, 32'h2);
    poll(rtc_cfg_pkg::IDX_CTRL, rtc_cfg_pkg::CTRL_SET_BIT, 1'b0);
    wr(4'h3, 32'h99);
    wr(rtc_cfg_pkg::IDX_CTRL, 32'h1);
    poll(rtc_cfg_pkg::IDX_CTRL, rtc_cfg_pkg::CTRL_CAP_BIT, 1'b0);
    rdc(4'h3, 32'h44, "snap byte3");
    rdc(4'h2, 32'h33, "snap byte2");
    rdc(4'h1, 32'h22, "snap byte1");
    apb(1'b0, 4'h0, 32'h0);
    chk({31'h0, rd > 32'h11 && rd < 32'h80}, 32'h1, "snap byte0");
    // clock enable low: timer must not advance
    snap0 = rd[7:0];
    @(posedge pclk);
    ce <= 1'b0;
    repeat (100) @(posedge pclk);
    ce <= 1'b1;
    wr(rtc_cfg_pkg::IDX_CTRL, 32'h1);
    poll(rtc_cfg_pkg::IDX_CTRL, rtc_cfg_pkg::CTRL_CAP_BIT, 1'b0);
    apb(1'b0, 4'h0, 32'h0);
    chk({31'h0, 8'(rd[7:0] - snap0) < 8'h40}, 32'h1, "timer frozen");
    rdc(rtc_cfg_pkg::IDX_STATUS, 32'h6, "cmd status");
    chk({31'h0, irq}, 32'h1, "irq cmd");
    wr(rtc_cfg_pkg::IDX_CLEAR, 32'h6);
    wr(rtc_cfg_pkg::IDX_STATUS, 32'h7);
    rdc(rtc_cfg_pkg::IDX_STATUS, 32'h0, "status cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // alarm at 0x100, programmed with alarm disabled
    wr(rtc_cfg_pkg::IDX_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) wr(4'(i + 8), (i == 1) ? 32'h1 : 32'h0);
    rdc(4'h9, 32'h1, "alarm byte1");
    for (int i = 0; i < 4; i++) wr(4'(i), 32'h0);
    wr(rtc_cfg_pkg::IDX_CTRL, 32'h2);
    poll(rtc_cfg_pkg::IDX_CTRL, rtc_cfg_pkg::CTRL_SET_BIT, 1'b0);
    wr(rtc_cfg_pkg::IDX_ENABLE, 32'h1);
    wr(rtc_cfg_pkg::IDX_CLEAR, 32'h7);
    wr(rtc_cfg_pkg::IDX_CTRL, 32'hC);
    settle();
    chk({31'h0, osc_mode_select}, 32'h1, "crystal mode");
    chk({31'h0, irq}, 32'h0, "irq idle");
    n = 0;
    while (alarm_event !== 1'b1 && n < 400) begin
      settle();
      n++;
    end
    chk({31'h0, n >= 200 && n <= 258}, 32'h1, "alarm moment");
    settle();
    chk({31'h0, irq}, 32'h1, "irq alarm");
    rdc(rtc_cfg_pkg::IDX_STATUS, 32'h1, "alarm status");
    wr(rtc_cfg_pkg::IDX_ENABLE, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(rtc_cfg_pkg::IDX_ENABLE, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(rtc_cfg_pkg::IDX_CLEAR, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0, "irq clear");
    wr(rtc_cfg_pkg::IDX_CTRL, 32'h0);
    settle();
    chk({31'h0, osc_mode_select}, 32'h0, "self mode");
    // unmapped places
    apb(1'b0, 4'h5, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, 4'hF, 32'hFF);
    chk({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b0, 4'h0, 32'h0, 2'h1);
    chk({31'h0, err}, 32'h1, "misaligned err");
    apb(1'b1, 4'h8, 32'h55, 2'h2);
    rdc(4'h8, 32'h0, "misaligned ignored");
    conclude();
  end
endmodule : rtc_timer_alarm_osc_config_tb
